// ### verilog/raster_expander_defs.vh
/*
  Constants for the raster bit expander: field codes, scan encoding, counts.
  Assumes plain Verilog-2005 tools; included by bare name from design files.
*/
// Function
// - Each raster byte is eight pixel selectors, one bit per pixel.
// - Bits within a byte are used from bit seven down to bit zero.
// - Byte order flag zero takes upper byte first, one takes lower first.
// - Swap and additive both zero: one bits foreground, zero bits background.
// - Swap flag one exchanges foreground and background roles.
// - Additive with zero bit skips the write but still steps one pixel.
// - No write ever lands outside the rectangular window.
// - At a window edge the rest of the byte is dropped.
// - Primary and secondary step directions come from the scan setting.
// - Without an explicit start, the first pixel follows from the scan setting.
// - Scale down uses bits 7,5,3,1 at 2:1 and bits 7,3 at 4:1.
// - With scaling installed the scale setting sets bits per pixel.
// - Address mode 01 offsets second offset, window and start by first offset.
// - Address mode 10 offsets window and start by second offset.
// - Only planes enabled by the plane mask are written.
// - Byte count from 0 to 65535, odd counts allowed.
// - Two bytes per word, both used before the next word is fetched.
`ifndef RASTER_EXPANDER_DEFS_VH
`define RASTER_EXPANDER_DEFS_VH

`define AMODE_ABS       2'h0
`define AMODE_OFS1      2'h1
`define AMODE_OFS2      2'h2

`define SCALE_1TO1      2'h0
`define SCALE_2TO1      2'h1
`define SCALE_4TO1      2'h2

// Scan bits: [0] x decrements, [1] y decrements, [2] primary axis is y
`define SCAN_XDEC_BIT   0
`define SCAN_YDEC_BIT   1
`define SCAN_YPRI_BIT   2

`define BYTE_MSB        3'h7
`define FIFO_DEPTH_DEF  16
`define COORD_W_DEF     16
`define PIX_W_DEF       12

`endif

// ### verilog/raster_word_mem.v
/*
  Small dual-port word store for the raster FIFO, registered read data.
  Assumes a single clock domain and a caller that never reads and writes
  the same slot in one cycle with an expectation of bypass.
*/
`timescale 1ns/10ps
module raster_word_mem #(
  parameter WIDTH = 16,
  parameter AW    = 4
) (
  // Clock
  input  wire             i_sys_clk,
  input  wire             i_ce,
  // Write side
  input  wire             i_wr_en,
  input  wire [AW-1:0]    i_wr_addr,
  input  wire [WIDTH-1:0] i_wr_data,
  // Read side
  input  wire             i_rd_en,
  input  wire [AW-1:0]    i_rd_addr,
  output reg  [WIDTH-1:0] o_rd_data
);
  reg [WIDTH-1:0] mem_reg [0:(1<<AW)-1];

  // No reset on the array: contents are only read after being written
  always @(posedge i_sys_clk) begin
    if (i_ce && i_wr_en) begin
      mem_reg[i_wr_addr] <= i_wr_data;
    end
    if (i_ce && i_rd_en) begin
      o_rd_data <= mem_reg[i_rd_addr];
    end
  end
endmodule // raster_word_mem

// ### verilog/raster_word_fifo.v
/*
  Synchronous FIFO of raster data words with valid/ready on both sides.
  Assumes one clock; the read data appears one cycle after a pop request
  is taken into the output register, so output is a one-entry skid stage.
*/
`timescale 1ns/10ps
module raster_word_fifo #(
  parameter WIDTH = 16,
  parameter AW    = 4
) (
  // Clock and reset
  input  wire             i_sys_clk,
  input  wire             i_arst_n,
  input  wire             i_ce,
  input  wire             i_flush,
  // Fill side
  input  wire             i_in_valid,
  output wire             o_in_ready,
  input  wire [WIDTH-1:0] i_in_data,
  // Drain side
  output reg              o_out_valid,
  input  wire             i_out_ready,
  output wire [WIDTH-1:0] o_out_data
);
  localparam [AW:0] DEPTH = 1 << AW;

  reg  [AW:0] wr_ptr_reg;
  reg  [AW:0] rd_ptr_reg;
  reg         in_ready_reg;
  wire [AW:0] used    = wr_ptr_reg - rd_ptr_reg;
  wire        empty   = (used == {(AW+1){1'b0}});
  wire        push    = i_in_valid && in_ready_reg;
  // Refill the output stage when it is empty or being drained
  wire        pop     = !empty && (!o_out_valid || i_out_ready);
  // Ready comes from a flop, so it is worked out from the next pointers
  wire [AW:0] wr_ptr_next = wr_ptr_reg + {{AW{1'b0}}, push};
  wire [AW:0] rd_ptr_next = rd_ptr_reg + {{AW{1'b0}}, pop};
  wire        full_next   = ((wr_ptr_next - rd_ptr_next) == DEPTH);

  assign o_in_ready = in_ready_reg;

  raster_word_mem #(
    .WIDTH (WIDTH),
    .AW    (AW)
  ) u_mem (
    .i_sys_clk (i_sys_clk),
    .i_ce      (i_ce),
    .i_wr_en   (push),
    .i_wr_addr (wr_ptr_reg[AW-1:0]),
    .i_wr_data (i_in_data),
    .i_rd_en   (pop),
    .i_rd_addr (rd_ptr_reg[AW-1:0]),
    .o_rd_data (o_out_data)
  );

  always @(posedge i_sys_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      wr_ptr_reg  <= {(AW+1){1'b0}};
      rd_ptr_reg  <= {(AW+1){1'b0}};
      o_out_valid <= 1'b0;
      in_ready_reg <= 1'b0;
    end else if (i_ce) begin
      if (i_flush) begin
        wr_ptr_reg  <= {(AW+1){1'b0}};
        rd_ptr_reg  <= {(AW+1){1'b0}};
        o_out_valid <= 1'b0;
        in_ready_reg <= 1'b1;
      end else begin
        in_ready_reg <= !full_next;
        if (push) begin
          wr_ptr_reg <= wr_ptr_reg + 1'b1;
        end
        if (pop) begin
          rd_ptr_reg  <= rd_ptr_reg + 1'b1;
          o_out_valid <= 1'b1;
        end else if (i_out_ready) begin
          o_out_valid <= 1'b0;
        end
      end
    end
  end
endmodule // raster_word_fifo

// ### verilog/raster_bit_expander.v
/*
  Raster bit expander: takes an instruction setup and a stream of 16-bit
  raster words, and turns each bit into a windowed pixel write.
  Assumes the host presents setup values stable while i_start pulses, and
  that the memory side accepts a write whenever o_wr_valid and i_wr_ready.
*/
`timescale 1ns/10ps
`include "raster_expander_defs.vh"
module raster_bit_expander #(
  parameter CW      = `COORD_W_DEF,
  parameter PW      = `PIX_W_DEF,
  parameter FIFO_AW = 4
) (
  // Clock, reset, enable
  input  wire          i_sys_clk,
  input  wire          i_arst_n,
  input  wire          i_ce,
  // Instruction setup, sampled on i_start
  input  wire          i_start,
  input  wire          i_additive_flag,
  input  wire          i_colour_swap_flag,
  input  wire          i_byte_order_flag,
  input  wire [1:0]    i_address_mode_field,
  input  wire [2:0]    i_scan,
  input  wire [1:0]    i_scale_x,
  input  wire [1:0]    i_scale_y,
  input  wire          i_scale_installed,
  input  wire [PW-1:0] i_foreground,
  input  wire [PW-1:0] i_background,
  input  wire [PW-1:0] i_plane_mask,
  input  wire [CW-1:0] i_ofs1_x,
  input  wire [CW-1:0] i_ofs1_y,
  input  wire          i_ofs2_given,
  input  wire [CW-1:0] i_ofs2_x,
  input  wire [CW-1:0] i_ofs2_y,
  input  wire [CW-1:0] i_win_x0,
  input  wire [CW-1:0] i_win_y0,
  input  wire [CW-1:0] i_win_x1,
  input  wire [CW-1:0] i_win_y1,
  input  wire          i_start_given,
  input  wire [CW-1:0] i_start_x,
  input  wire [CW-1:0] i_start_y,
  input  wire [15:0]   i_byte_count,
  // Raster data words
  input  wire          i_data_valid,
  output wire          o_data_ready,
  input  wire [15:0]   i_data,
  // Refresh memory writes
  output reg           o_wr_valid,
  input  wire          i_wr_ready,
  output reg  [CW-1:0] o_wr_x,
  output reg  [CW-1:0] o_wr_y,
  output reg  [PW-1:0] o_wr_value,
  output reg  [PW-1:0] o_wr_plane_mask,
  // Status
  output reg           o_busy,
  output reg           o_done
);
  localparam [1:0] ST_IDLE = 2'h0;
  localparam [1:0] ST_LOAD = 2'h1;
  localparam [1:0] ST_BITS = 2'h2;

  // Is bit idx used under the given scale; 2:1 keeps odd bits, 4:1 keeps 7 and 3
  function bit_used;
    input [1:0] scale;
    input [2:0] idx;
    begin
      case (scale)
        `SCALE_2TO1: bit_used = idx[0];
        `SCALE_4TO1: bit_used = (idx[1:0] == 2'h3);
        default:     bit_used = 1'b1;
      endcase
    end
  endfunction

  reg  [1:0]    state_reg;
  reg           additive_reg;
  reg           swap_reg;
  reg           order_reg;
  reg  [2:0]    scan_reg;
  reg  [1:0]    scale_reg;
  reg  [PW-1:0] fg_reg;
  reg  [PW-1:0] bg_reg;
  reg  [CW-1:0] wx0_reg;
  reg  [CW-1:0] wy0_reg;
  reg  [CW-1:0] wx1_reg;
  reg  [CW-1:0] wy1_reg;
  reg  [CW-1:0] cx_reg;
  reg  [CW-1:0] cy_reg;
  reg  [16:0]   bytes_left_reg;
  reg  [15:0]   word_reg;
  reg           second_reg;
  reg  [2:0]    bit_reg;

  // Address-mode offsets applied to setup values
  reg  [CW-1:0] o2x;
  reg  [CW-1:0] o2y;
  reg  [CW-1:0] ax;
  reg  [CW-1:0] ay;
  always @* begin
    o2x = i_ofs2_x;
    o2y = i_ofs2_y;
    ax  = {CW{1'b0}};
    ay  = {CW{1'b0}};
    if (i_address_mode_field == `AMODE_OFS1) begin
      ax = i_ofs1_x;
      ay = i_ofs1_y;
      if (i_ofs2_given) begin
        o2x = i_ofs2_x + i_ofs1_x;
        o2y = i_ofs2_y + i_ofs1_y;
      end
    end else if (i_address_mode_field == `AMODE_OFS2) begin
      ax = i_ofs2_x;
      ay = i_ofs2_y;
    end
  end

  wire [CW-1:0] n_wx0 = i_win_x0 + ax;
  wire [CW-1:0] n_wy0 = i_win_y0 + ay;
  wire [CW-1:0] n_wx1 = i_win_x1 + ax;
  wire [CW-1:0] n_wy1 = i_win_y1 + ay;
  wire          unused_o2 = ^{o2x, o2y};

  // Implicit start is the window corner the scan begins from
  wire [CW-1:0] def_x = i_scan[`SCAN_XDEC_BIT] ? n_wx1 : n_wx0;
  wire [CW-1:0] def_y = i_scan[`SCAN_YDEC_BIT] ? n_wy1 : n_wy0;

  // Scan-driven stepping
  wire xdec = scan_reg[`SCAN_XDEC_BIT];
  wire ydec = scan_reg[`SCAN_YDEC_BIT];
  wire ypri = scan_reg[`SCAN_YPRI_BIT];
  wire [CW-1:0] x_step = xdec ? cx_reg - 1'b1 : cx_reg + 1'b1;
  wire [CW-1:0] y_step = ydec ? cy_reg - 1'b1 : cy_reg + 1'b1;
  wire x_edge = xdec ? (cx_reg == wx0_reg) : (cx_reg == wx1_reg);
  wire y_edge = ydec ? (cy_reg == wy0_reg) : (cy_reg == wy1_reg);
  wire pri_edge = ypri ? y_edge : x_edge;
  wire [CW-1:0] x_wrap = xdec ? wx1_reg : wx0_reg;
  wire [CW-1:0] y_wrap = ydec ? wy1_reg : wy0_reg;

  wire in_win = (cx_reg >= wx0_reg) && (cx_reg <= wx1_reg) &&
                (cy_reg >= wy0_reg) && (cy_reg <= wy1_reg);

  // Current byte according to byte order
  wire [7:0] cur_byte = (second_reg ^ order_reg) ? word_reg[7:0] : word_reg[15:8];
  wire       cur_bit  = cur_byte[bit_reg];
  wire       use_bit  = bit_used(scale_reg, bit_reg);
  // A skipped scaled bit at the edge must not end the byte before the edge pixel
  wire       last_bit = (bit_reg == 3'h0) || (use_bit && pri_edge);
  wire [PW-1:0] one_val  = swap_reg ? bg_reg : fg_reg;
  wire [PW-1:0] zero_val = swap_reg ? fg_reg : bg_reg;
  wire          do_write = use_bit && in_win && (cur_bit || !additive_reg);

  wire stall     = o_wr_valid && !i_wr_ready;
  wire fifo_v;
  wire [15:0] fifo_d;
  wire fifo_take = (state_reg == ST_LOAD) && fifo_v;

  raster_word_fifo #(
    .WIDTH (16),
    .AW    (FIFO_AW)
  ) u_fifo (
    .i_sys_clk   (i_sys_clk),
    .i_arst_n    (i_arst_n),
    .i_ce        (i_ce),
    .i_flush     (i_start),
    .i_in_valid  (i_data_valid),
    .o_in_ready  (o_data_ready),
    .i_in_data   (i_data),
    .o_out_valid (fifo_v),
    .i_out_ready (fifo_take),
    .o_out_data  (fifo_d)
  );

  always @(posedge i_sys_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      state_reg       <= ST_IDLE;
      additive_reg    <= 1'b0;
      swap_reg        <= 1'b0;
      order_reg       <= 1'b0;
      scan_reg        <= 3'h0;
      scale_reg       <= `SCALE_1TO1;
      fg_reg          <= {PW{1'b0}};
      bg_reg          <= {PW{1'b0}};
      wx0_reg         <= {CW{1'b0}};
      wy0_reg         <= {CW{1'b0}};
      wx1_reg         <= {CW{1'b0}};
      wy1_reg         <= {CW{1'b0}};
      cx_reg          <= {CW{1'b0}};
      cy_reg          <= {CW{1'b0}};
      bytes_left_reg  <= 17'h0_0000;
      word_reg        <= 16'h0000;
      second_reg      <= 1'b0;
      bit_reg         <= `BYTE_MSB;
      o_wr_valid      <= 1'b0;
      o_wr_x          <= {CW{1'b0}};
      o_wr_y          <= {CW{1'b0}};
      o_wr_value      <= {PW{1'b0}};
      o_wr_plane_mask <= {PW{1'b0}};
      o_busy          <= 1'b0;
      o_done          <= 1'b0;
    end else if (i_ce) begin
      o_done <= 1'b0;
      if (o_wr_valid && i_wr_ready) begin
        o_wr_valid <= 1'b0;
      end
      case (state_reg)
        ST_IDLE: begin
          if (i_start) begin
            additive_reg    <= i_additive_flag;
            swap_reg        <= i_colour_swap_flag;
            order_reg       <= i_byte_order_flag;
            scan_reg        <= i_scan;
            // Scale only when installed; the primary axis picks the ratio
            scale_reg       <= !i_scale_installed ? `SCALE_1TO1 :
                               (i_scan[`SCAN_YPRI_BIT] ? i_scale_y : i_scale_x);
            fg_reg          <= i_foreground;
            bg_reg          <= i_background;
            o_wr_plane_mask <= i_plane_mask;
            wx0_reg         <= n_wx0;
            wy0_reg         <= n_wy0;
            wx1_reg         <= n_wx1;
            wy1_reg         <= n_wy1;
            // Explicit start assumed inside the window by the host
            cx_reg          <= i_start_given ? i_start_x + ax : def_x;
            cy_reg          <= i_start_given ? i_start_y + ay : def_y;
            bytes_left_reg  <= {1'b0, i_byte_count};
            o_busy          <= (i_byte_count != 16'h0000);
            o_done          <= (i_byte_count == 16'h0000) | unused_o2 & 1'b0;
            state_reg       <= (i_byte_count != 16'h0000) ? ST_LOAD : ST_IDLE;
          end
        end
        ST_LOAD: begin
          if (fifo_v) begin
            word_reg   <= fifo_d;
            second_reg <= 1'b0;
            bit_reg    <= `BYTE_MSB;
            state_reg  <= ST_BITS;
          end
        end
        ST_BITS: begin
          // Hold position while the memory side back-pressures
          if (!stall) begin
            if (do_write) begin
              o_wr_valid <= 1'b1;
              o_wr_x     <= cx_reg;
              o_wr_y     <= cy_reg;
              o_wr_value <= cur_bit ? one_val : zero_val;
            end
            if (use_bit) begin
              if (pri_edge) begin
                // Secondary step and wrap of the primary coordinate
                if (ypri) begin
                  cy_reg <= y_wrap;
                  cx_reg <= x_step;
                end else begin
                  cx_reg <= x_wrap;
                  cy_reg <= y_step;
                end
              end else if (ypri) begin
                cy_reg <= y_step;
              end else begin
                cx_reg <= x_step;
              end
            end
            if (last_bit || (use_bit && pri_edge)) begin
              bit_reg        <= `BYTE_MSB;
              bytes_left_reg <= bytes_left_reg - 1'b1;
              if (bytes_left_reg == 17'h0_0001) begin
                // Odd count: trailing byte of the last word is dropped
                state_reg <= ST_IDLE;
                o_busy    <= 1'b0;
                o_done    <= 1'b1;
              end else if (second_reg) begin
                state_reg <= ST_LOAD;
              end else begin
                second_reg <= 1'b1;
              end
            end else begin
              bit_reg <= bit_reg - 1'b1;
            end
          end
        end
        default: state_reg <= ST_IDLE;
      endcase
    end
  end
endmodule // raster_bit_expander

// ### sim/raster_expander_chk_sva.sv
/* Port checker for raster_bit_expander, attached by bind.
   Assumes setup inputs stay steady while an instruction runs. */
`timescale 1ns/10ps
module raster_expander_chk #(
  parameter CW = 16,
  parameter PW = 12
) (
  // Clock and control
  input wire          i_sys_clk,
  input wire          i_arst_n,
  input wire          i_start,
  input wire          i_additive_flag,
  input wire          i_colour_swap_flag,
  input wire [1:0]    i_address_mode_field,
  // Setup values
  input wire [PW-1:0] i_foreground,
  input wire [PW-1:0] i_background,
  input wire [PW-1:0] i_plane_mask,
  input wire [CW-1:0] i_ofs1_x,
  input wire [CW-1:0] i_ofs2_x,
  input wire [CW-1:0] i_win_x0,
  input wire [CW-1:0] i_win_x1,
  input wire [15:0]   i_byte_count,
  // Writes and status
  input wire          i_wr_ready,
  input wire          o_wr_valid,
  input wire [CW-1:0] o_wr_x,
  input wire [PW-1:0] o_wr_value,
  input wire [PW-1:0] o_wr_plane_mask,
  input wire          o_busy,
  input wire          o_done
);
  // Only x is watched here; y edges follow the same offset rule
  wire [CW-1:0] ofs_x = (i_address_mode_field == 2'h1) ? i_ofs1_x :
                        (i_address_mode_field == 2'h2) ? i_ofs2_x : {CW{1'b0}};
  wire [PW-1:0] one_val = i_colour_swap_flag ? i_background : i_foreground;
  default clocking cb @(posedge i_sys_clk); endclocking
  default disable iff (!i_arst_n);
  property p_hold;
    o_wr_valid && !i_wr_ready |=> o_wr_valid && $stable(o_wr_x) && $stable(o_wr_value);
  endproperty
  a_hold: assert property (p_hold) else $error("write changed before accept");
  property p_win;
    o_wr_valid |-> o_wr_x >= i_win_x0 + ofs_x && o_wr_x <= i_win_x1 + ofs_x;
  endproperty
  a_win: assert property (p_win) else $error("write outside window");
  property p_mask;
    o_wr_valid |-> o_wr_plane_mask == i_plane_mask;
  endproperty
  a_mask: assert property (p_mask) else $error("plane mask wrong");
  property p_add;
    o_wr_valid && i_additive_flag |-> ((o_wr_value ^ one_val) & i_plane_mask) == 0;
  endproperty
  a_add: assert property (p_add) else $error("additive write value wrong");
  property p_val;
    o_wr_valid |-> ((o_wr_value ^ i_foreground) & i_plane_mask) == 0 ||
                   ((o_wr_value ^ i_background) & i_plane_mask) == 0;
  endproperty
  a_val: assert property (p_val) else $error("write value not a colour");
  property p_pulse;
    o_done |=> !o_done;
  endproperty
  a_pulse: assert property (p_pulse) else $error("done longer than one cycle");
  property p_zero;
    i_start && !o_busy && i_byte_count == 16'h0000 |-> ##[1:2] o_done;
  endproperty
  a_zero: assert property (p_zero) else $error("empty instruction not done");
  property p_busy;
    $rose(o_busy) |-> $past(i_start);
  endproperty
  a_busy: assert property (p_busy) else $error("busy without start");
  c_add: cover property (o_wr_valid && i_additive_flag);
  c_stall: cover property (o_wr_valid && !i_wr_ready);
  c_done: cover property (o_done);
endmodule // raster_expander_chk

bind raster_bit_expander raster_expander_chk #(.CW(CW), .PW(PW)) u_chk (
  .i_sys_clk(i_sys_clk), .i_arst_n(i_arst_n), .i_start(i_start),
  .i_additive_flag(i_additive_flag), .i_colour_swap_flag(i_colour_swap_flag),
  .i_address_mode_field(i_address_mode_field), .i_foreground(i_foreground),
  .i_background(i_background), .i_plane_mask(i_plane_mask), .i_ofs1_x(i_ofs1_x),
  .i_ofs2_x(i_ofs2_x), .i_win_x0(i_win_x0), .i_win_x1(i_win_x1),
  .i_byte_count(i_byte_count), .i_wr_ready(i_wr_ready), .o_wr_valid(o_wr_valid),
  .o_wr_x(o_wr_x), .o_wr_value(o_wr_value), .o_wr_plane_mask(o_wr_plane_mask),
  .o_busy(o_busy), .o_done(o_done)
);

// ### sim/raster_host_model.sv
/* Host model: sends queued raster words on valid/ready.
   Assumes words are queued only after the instruction start. */
`timescale 1ns/10ps
module raster_host_model (
  // Clock and pacing
  input  wire        i_sys_clk,
  input  wire        i_gap,
  // Word stream
  output reg         o_data_valid,
  input  wire        i_data_ready,
  output reg  [15:0] o_data
);
  logic [15:0] words[$];
  logic        taken = 1'b0;
  initial begin
    o_data_valid = 1'b0;
    o_data = 16'h0000;
  end
  always @(posedge i_sys_clk) taken <= o_data_valid && i_data_ready;
  always @(negedge i_sys_clk) begin
    if (taken) void'(words.pop_front());
    // Valid is set once per step: dropped between words while i_gap is high, never dropped before a take
    if (taken || !o_data_valid) begin
      if (words.size() > 0 && !i_gap) begin
        o_data_valid = 1'b1;
        o_data = words[0];
      end else begin
        o_data_valid = 1'b0;
        // Idle data toggles so a stale word is never mistaken for a fresh one
        o_data = ~o_data;
      end
    end
  end
endmodule // raster_host_model

// ### sim/raster_bit_expander_tb_top.sv
/* Bench for raster_bit_expander: random instructions, queued pixel writes.
   Assumes the host model feeds words and this module paces memory writes. */
`timescale 1ns/10ps
`define CHK(a, e) begin checks++; if ((a) !== (e)) begin miscompares++; \
  $display("Error %0t: value mismatch", $time); end end
module raster_bit_expander_tb_top;
  logic        i_sys_clk = 1'b0, i_arst_n = 1'b0, i_start = 1'b0;
  logic        add = 1'b0, swap = 1'b0, order = 1'b0, inst = 1'b0, sgiven = 1'b0;
  logic        wr_ready = 1'b0, gap = 1'b0, stall = 1'b0;
  logic [1:0]  mode = 2'h0, sclx = 2'h0, scly = 2'h0;
  logic [2:0]  scan = 3'h0;
  logic [11:0] fg = 12'h000, bg = 12'h000, pm = 12'h000;
  logic [15:0] o1x = 16'h0000, o1y = 16'h0000, o2x = 16'h0000, o2y = 16'h0000;
  logic [15:0] wx0 = 16'h0000, wy0 = 16'h0000, wx1 = 16'h0000, wy1 = 16'h0000;
  logic [15:0] stx = 16'h0000, sty = 16'h0000, cnt = 16'h0000;
  wire         dvalid, dready, wvalid, busy, done;
  wire  [15:0] ddata, wx, wy;
  wire  [11:0] wval, wmask;
  logic [43:0] exq[$];
  integer      seed, miscompares = 0, checks = 0, t;
  int          cnts[6] = '{0, 1, 2, 7, 15, 16};

  raster_bit_expander u_dut (
    .i_sys_clk(i_sys_clk), .i_arst_n(i_arst_n), .i_ce(1'b1), .i_start(i_start),
    .i_additive_flag(add), .i_colour_swap_flag(swap), .i_byte_order_flag(order),
    .i_address_mode_field(mode), .i_scan(scan), .i_scale_x(sclx), .i_scale_y(scly),
    .i_scale_installed(inst), .i_foreground(fg), .i_background(bg), .i_plane_mask(pm),
    .i_ofs1_x(o1x), .i_ofs1_y(o1y), .i_ofs2_given(1'b1), .i_ofs2_x(o2x), .i_ofs2_y(o2y),
    .i_win_x0(wx0), .i_win_y0(wy0), .i_win_x1(wx1), .i_win_y1(wy1),
    .i_start_given(sgiven), .i_start_x(stx), .i_start_y(sty), .i_byte_count(cnt),
    .i_data_valid(dvalid), .o_data_ready(dready), .i_data(ddata),
    .o_wr_valid(wvalid), .i_wr_ready(wr_ready), .o_wr_x(wx), .o_wr_y(wy),
    .o_wr_value(wval), .o_wr_plane_mask(wmask), .o_busy(busy), .o_done(done)
  );
  raster_host_model host (
    .i_sys_clk(i_sys_clk), .i_gap(gap), .o_data_valid(dvalid),
    .i_data_ready(dready), .o_data(ddata)
  );

  always #2 i_sys_clk = ~i_sys_clk;
  always @(negedge i_sys_clk) begin
    wr_ready <= !stall && ($random(seed) & 3) != 0;
    gap <= ($random(seed) & 3) == 0;
  end
  always @(posedge i_sys_clk) begin
    if (wvalid && wr_ready) begin
      if (exq.size() == 0) `CHK(1'b1, 1'b0)
      else `CHK({wx, wy, wval & pm}, exq.pop_front())
    end
  end

  task close_out;
    if (miscompares == 0 && checks > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask

  // Expected writes for the words given, walked pixel by pixel
  task automatic note_writes(input logic [15:0] w[$]);
    logic [15:0] ox, oy, p0, p1, s0, s1, pr, se;
    logic [7:0]  b;
    logic        yp, pd, sd;
    logic [1:0]  sc;
    int          st, k, n;
    ox = mode == 2'h1 ? o1x : (mode == 2'h2 ? o2x : 16'h0000);
    oy = mode == 2'h1 ? o1y : (mode == 2'h2 ? o2y : 16'h0000);
    yp = scan[2];
    pd = yp ? scan[1] : scan[0];
    sd = yp ? scan[0] : scan[1];
    p0 = yp ? wy0 + oy : wx0 + ox;
    p1 = yp ? wy1 + oy : wx1 + ox;
    s0 = yp ? wx0 + ox : wy0 + oy;
    s1 = yp ? wx1 + ox : wy1 + oy;
    pr = sgiven ? (yp ? sty + oy : stx + ox) : (pd ? p1 : p0);
    se = sgiven ? (yp ? stx + ox : sty + oy) : (sd ? s1 : s0);
    sc = yp ? scly : sclx;
    st = !inst ? 1 : (sc == 2'h1 ? 2 : (sc == 2'h2 ? 4 : 1));
    for (n = 0; n < cnt; n++) begin
      b = (n[0] ^ order) ? w[n / 2][7:0] : w[n / 2][15:8];
      for (k = 7; k >= 0; k -= st) begin
        if ((b[k] || !add) && se >= s0 && se <= s1)
          exq.push_back({yp ? se : pr, yp ? pr : se, ((b[k] ^ swap) ? fg : bg) & pm});
        if (pr == (pd ? p0 : p1)) begin
          pr = pd ? p1 : p0;
          se = sd ? se - 16'h0001 : se + 16'h0001;
          break;
        end
        pr = pd ? pr - 16'h0001 : pr + 16'h0001;
      end
    end
  endtask

  task automatic run;
    logic [15:0] w[$];
    int          i;
    for (i = 0; i < (cnt + 1) / 2; i++) w.push_back(16'($random(seed)));
    note_writes(w);
    @(negedge i_sys_clk);
    i_start = 1'b1;
    @(negedge i_sys_clk);
    i_start = 1'b0;
    foreach (w[i]) host.words.push_back(w[i]);
    for (i = 0; i < 4000 && done !== 1'b1; i++) @(negedge i_sys_clk);
    if (i == 4000) begin
      miscompares++;
      close_out;
    end
    // The last write may still wait for the memory side after done
    for (i = 0; i < 200 && wvalid !== 1'b0; i++) @(negedge i_sys_clk);
    if (i == 200) begin
      miscompares++;
      close_out;
    end
    `CHK(exq.size(), 0)
  endtask

  task automatic setup(input int n);
    {add, swap, order, scan} = 6'(n);
    mode = 2'(n % 3);
    cnt = 16'(cnts[n % 6]);
    {inst, sgiven, sclx, scly} = 6'($random(seed));
    {fg, bg, pm} = 36'({$random(seed), $random(seed)});
    {o1x, o1y, o2x, o2y} = {4{16'({$random(seed)} % 64)}};
    wx0 = 16'({$random(seed)} % 64);
    wy0 = 16'({$random(seed)} % 64);
    wx1 = wx0 + 16'({$random(seed)} % 12);
    wy1 = wy0 + 16'({$random(seed)} % 6);
    stx = wx0 + 16'({$random(seed)} % (wx1 - wx0 + 1));
    sty = wy0 + 16'({$random(seed)} % (wy1 - wy0 + 1));
  endtask

  initial begin
    seed = 32'ha1d8_3947;
    repeat (12) @(posedge i_sys_clk);
    @(negedge i_sys_clk);
    i_arst_n = 1'b1;
    for (t = 0; t < 64; t++) begin
      setup(t);
      run();
    end
    // Memory stalls while the host keeps sending, so the buffer must refuse
    setup(9);
    cnt = 16'd60;
    stall = 1'b1;
    fork
      run();
      begin
        repeat (150) @(negedge i_sys_clk);
        `CHK(dready, 1'b0)
        stall = 1'b0;
      end
    join
    close_out;
  end
endmodule // raster_bit_expander_tb_top
